// >>> src/hap_pkg.sv
// Shared constants, types and reset state of the handset audio path config
package hap_pkg;

  // Register indices on the plain register port
  localparam logic [7:0] REG_ACTIVE = 8'h00;
  localparam logic [7:0] REG_PRESET_BASE = 8'h01;
  localparam logic [7:0] REG_MODE = 8'h06;
  localparam logic [7:0] REG_CFG = 8'h07;
  localparam logic [7:0] REG_VOL = 8'h08;
  localparam logic [7:0] REG_MIC = 8'h09;
  localparam logic [7:0] REG_EQ_CMD = 8'h0A;
  localparam logic [7:0] REG_STATUS = 8'h0B;
  localparam logic [7:0] REG_VGAIN_BASE = 8'h10;
  localparam logic [7:0] REG_EQ_BASE = 8'h20;

  // Speaker control word field positions
  localparam int GAIN_LSB = 11;
  localparam int GND_OFF_BIT = 10;
  localparam int SE_BIT = 9;
  localparam int HS_OFF_BIT = 8;
  localparam int HS_SRC_LSB = 6;
  localparam int N_OFF_BIT = 5;
  localparam int N_SRC_LSB = 3;
  localparam int P_OFF_BIT = 2;
  localparam int P_SRC_LSB = 0;

  // Output source encodings
  localparam logic [1:0] SRC_GND = 2'h0;
  localparam logic [1:0] SRC_BUZZER = 2'h1;
  localparam logic [1:0] SRC_DIFF = 2'h2;
  localparam logic [1:0] SRC_SE = 2'h3;

  // Masks derived from field positions
  localparam logic [15:0] OFF_MASK = 16'h0524;
  localparam logic [15:0] SRC_SE_MASK = 16'h02DB;

  // Preset speaker words per mode
  localparam logic [15:0] PRESET_IDLE = 16'h1D36;
  localparam logic [15:0] PRESET_M1 = 16'h1912;
  localparam logic [15:0] PRESET_M2 = 16'h0B33;
  localparam logic [15:0] PRESET_M3 = 16'h1AF6;
  localparam logic [15:0] PRESET_M4 = 16'h0333;
  localparam logic [15:0] SPK_RST_OUT = 16'h1D24;

  // Volume, microphone, equaliser and sidetone settings
  localparam int NUM_MODES = 5;
  localparam int NUM_VOL_STEPS = 10;
  localparam int NUM_EQ = 4;
  localparam logic [3:0] VOL_STEP_MAX = 4'h9;
  localparam logic [3:0] VOL_STEP_RST = 4'h5;
  localparam logic [15:0] VOL_GAIN_RST = 16'h4000;
  localparam logic [15:0] EQ_BYPASS = 16'h7FFF;
  localparam logic [3:0] MIC_GAIN_RST = 4'h7;
  localparam logic [3:0] MIC_DAMP_STEP = 4'h1;
  localparam logic [7:0] SIDETONE_RST = 8'h10;

  typedef enum logic [2:0] {
    MODE_IDLE, MODE_EARPIECE, MODE_SPEAKER, MODE_HEADSET, MODE_ALERT
  } hap_mode_t;

  typedef enum logic {ST_RUN, ST_LOAD} hap_fsm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } hap_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] sample;
    logic [15:0] tone;
  } hap_audio_in_t;

  typedef struct packed {
    logic valid;
    logic [15:0] sample;
  } hap_audio_out_t;

  typedef struct packed {
    hap_fsm_t fsm;
    hap_mode_t mode;
    logic [15:0] active;
    logic [NUM_MODES-1:0][15:0] presets;
    logic shut_dis;
    logic [7:0] sidetone_lvl;
    logic [3:0] vol_step;
    logic [3:0] mic_base;
    logic [NUM_VOL_STEPS-1:0][15:0] vgain;
    logic [NUM_EQ-1:0][15:0] eq;
    logic [15:0] rdata;
    logic [15:0] spk_out;
    logic vref_en;
    logic sidetone_en;
    logic aec_en;
    logic alert_en;
    logic [3:0] mic_gain;
    hap_audio_out_t audio;
  } hap_state_t;

  localparam hap_state_t HAP_STATE_RST = '{
    fsm: ST_RUN,
    mode: MODE_IDLE,
    active: PRESET_IDLE,
    presets: {PRESET_M4, PRESET_M3, PRESET_M2, PRESET_M1, PRESET_IDLE},
    shut_dis: 1'b0,
    sidetone_lvl: SIDETONE_RST,
    vol_step: VOL_STEP_RST,
    mic_base: MIC_GAIN_RST,
    vgain: {NUM_VOL_STEPS{VOL_GAIN_RST}},
    eq: {NUM_EQ{EQ_BYPASS}},
    rdata: 16'h0000,
    spk_out: SPK_RST_OUT,
    vref_en: 1'b0,
    sidetone_en: 1'b0,
    aec_en: 1'b0,
    alert_en: 1'b0,
    mic_gain: MIC_GAIN_RST,
    audio: '{valid: 1'b0, sample: 16'h0000}
  };

endpackage

// >>> src/hap_vol_stage.sv
// Volume stage: tone mix, doubling and signed fraction scaling
`timescale 1ns/10ps
`default_nettype none
module hap_vol_stage
  import hap_pkg::*;
(
  input wire logic [15:0] sample_i,
  input wire logic [15:0] tone_i,
  input wire logic [15:0] gain_i,
  output logic [15:0] scaled_o
);
  logic signed [16:0] sum;
  logic signed [15:0] mixed;
  logic signed [31:0] prod;

  // Tones mixed first, so volume also scales them
  always_comb
  begin
    sum = 17'(signed'(sample_i)) + 17'(signed'(tone_i));
    if (sum[16] != sum[15])
      mixed = sum[16] ? 16'sh8000 : 16'sh7FFF;
    else
      mixed = sum[15:0];
    prod = mixed * signed'(gain_i);
    // Shift by 14 instead of 15 gives the built-in doubling
    if (prod[31:29] == 3'h0 || prod[31:29] == 3'h7)
      scaled_o = prod[29:14];
    else
      scaled_o = prod[31] ? 16'h8000 : 16'h7FFF;
  end
endmodule
`default_nettype wire

// >>> src/hap_top.sv
// Handset audio path configuration bank with volume stage and mode presets
`timescale 1ns/10ps
`default_nettype none
//Function
// - Bits 13-11 pick speaker gain, 000 is +2 dB, 111 is -12 dB.
// - Bit 10 powers off ground amp; kept on while other amps run.
// - Bit 9 enables differential to single-ended conversion.
// - Bit 8 powers off the headset speaker amp.
// - Bits 7-6 choose headset source: ground, buzzer, positive diff, single-ended.
// - Bit 5 powers off the negative speaker amp.
// - Bits 4-3 choose negative source: ground, buzzer, negative diff, single-ended.
// - Bit 2 powers off the positive speaker amp.
// - Bits 1-0 choose positive source: ground, buzzer, positive diff, single-ended.
// - Stored speaker word per idle and four modes, with given defaults.
// - Idle shuts all amps and references unless configuration disables it.
// - Earpiece mode adds sidetone at stored level, volume host adjustable.
// - Speakerphone keeps echo canceller on, no sidetone, volume adjustable.
// - Alert mode plays tones on loudspeaker, volume adjustable.
// - Ten volume steps with gains held in stored configuration.
// - Gains are 16-bit signed fractions, maximum 0x7fff.
// - Volume stage doubles input; 0x0000 to 0x4000 spans up to unity.
// - Step with bit 15 set lowers microphone gain by 2 dB.
// - Microphone damping never exceeds 2 dB in total.
// - Four equalisers, default bypass, reloadable by command.
// - Volume stage follows tone insertion, so tones are scaled.
// - Microphone gain steps 2 dB, 0000 is 0 dB, 1111 is +30 dB.
module hap_top
  import hap_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire hap_bus_req_t bus_i,
  input wire hap_audio_in_t audio_i,
  output logic [15:0] rdata_o,
  output logic [15:0] spk_ctrl_o,
  output logic vref_en_o,
  output logic sidetone_en_o,
  output logic [7:0] sidetone_level_o,
  output logic aec_en_o,
  output logic alert_tone_en_o,
  output logic [3:0] mic_gain_o,
  output logic [NUM_EQ-1:0][15:0] eq_coef_o,
  output hap_audio_out_t audio_o
);
  hap_state_t st_reg;
  hap_state_t st_next;
  logic [15:0] step_gain;
  logic [15:0] scaled;
  logic damp;
  logic idle_shut;
  logic [15:0] eff;

  // Selected step gain; bit 15 is the damping flag, magnitude feeds the stage
  assign step_gain = st_reg.vgain[st_reg.vol_step];
  assign damp = step_gain[15];
  assign idle_shut = (st_reg.mode == MODE_IDLE) && !st_reg.shut_dis;

  hap_vol_stage u_vol
  (
    .sample_i(audio_i.sample),
    .tone_i(audio_i.tone),
    .gain_i({1'b0, step_gain[14:0]}),
    .scaled_o(scaled)
  );

  // Effective speaker word seen by the analogue amplifiers
  always_comb
  begin
    eff = st_reg.active;
    if (idle_shut)
    begin
      eff = (st_reg.active & ~SRC_SE_MASK) | OFF_MASK;
    end
    else if (!eff[P_OFF_BIT] || !eff[N_OFF_BIT] || !eff[HS_OFF_BIT])
    begin
      eff[GND_OFF_BIT] = 1'b0;
    end
  end

  // Next state: register port, mode sequencing, outputs
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = 16'h0000;
    // Mode sequencing: preset lands in the active word after one load cycle
    case (st_reg.fsm)
      ST_LOAD:
      begin
        st_next.active = st_reg.presets[st_reg.mode];
        st_next.fsm = ST_RUN;
      end
      ST_RUN:
      begin
        st_next.fsm = ST_RUN;
      end
      default:
      begin
        st_next.fsm = ST_RUN;
      end
    endcase
    // Register writes
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        REG_ACTIVE: st_next.active = bus_i.wdata;
        REG_MODE:
        begin
          if (bus_i.wdata[2:0] <= 3'(MODE_ALERT))
          begin
            st_next.mode = hap_mode_t'(bus_i.wdata[2:0]);
            st_next.fsm = ST_LOAD;
          end
        end
        REG_CFG:
        begin
          st_next.shut_dis = bus_i.wdata[0];
          st_next.sidetone_lvl = bus_i.wdata[15:8];
        end
        REG_VOL:
        begin
          // Host volume command, refused in idle or beyond the last step
          if (st_reg.mode != MODE_IDLE && bus_i.wdata[3:0] <= VOL_STEP_MAX)
            st_next.vol_step = bus_i.wdata[3:0];
        end
        REG_MIC: st_next.mic_base = bus_i.wdata[3:0];
        default:
        begin
        end
      endcase
      for (int i = 0; i < NUM_MODES; i++)
      begin
        if (bus_i.addr == REG_PRESET_BASE + 8'(i))
          st_next.presets[i] = bus_i.wdata;
      end
      for (int i = 0; i < NUM_VOL_STEPS; i++)
      begin
        if (bus_i.addr == REG_VGAIN_BASE + 8'(i))
          st_next.vgain[i] = bus_i.wdata;
      end
      for (int i = 0; i < NUM_EQ; i++)
      begin
        if (bus_i.addr == REG_EQ_BASE + 8'(i))
          st_next.eq[i] = bus_i.wdata;
        else if (bus_i.addr == REG_EQ_CMD && bus_i.wdata[i])
          st_next.eq[i] = EQ_BYPASS;
      end
    end
    // Register reads, data valid in the following cycle only
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        REG_ACTIVE: st_next.rdata = st_reg.active;
        REG_MODE: st_next.rdata = {13'h0000, st_reg.mode};
        REG_CFG: st_next.rdata = {st_reg.sidetone_lvl, 7'h00, st_reg.shut_dis};
        REG_VOL: st_next.rdata = {12'h000, st_reg.vol_step};
        REG_MIC: st_next.rdata = {12'h000, st_reg.mic_base};
        REG_STATUS:
        begin
          st_next.rdata = {8'h00, st_reg.mic_gain, damp, st_reg.vref_en,
                           st_reg.fsm == ST_LOAD, st_reg.mode == MODE_IDLE};
        end
        default: st_next.rdata = 16'h0000;
      endcase
      for (int i = 0; i < NUM_MODES; i++)
      begin
        if (bus_i.addr == REG_PRESET_BASE + 8'(i))
          st_next.rdata = st_reg.presets[i];
      end
      for (int i = 0; i < NUM_VOL_STEPS; i++)
      begin
        if (bus_i.addr == REG_VGAIN_BASE + 8'(i))
          st_next.rdata = st_reg.vgain[i];
      end
      for (int i = 0; i < NUM_EQ; i++)
      begin
        if (bus_i.addr == REG_EQ_BASE + 8'(i))
          st_next.rdata = st_reg.eq[i];
      end
    end
    // Amplifier and front-end controls
    st_next.spk_out = eff;
    st_next.vref_en = !idle_shut;
    st_next.sidetone_en = (st_reg.mode == MODE_EARPIECE) || (st_reg.mode == MODE_HEADSET);
    st_next.aec_en = (st_reg.mode == MODE_SPEAKER);
    st_next.alert_en = (st_reg.mode == MODE_ALERT);
    // Damping takes one 2 dB code at most, never below 0 dB
    if (damp && st_reg.mic_base >= MIC_DAMP_STEP)
      st_next.mic_gain = st_reg.mic_base - MIC_DAMP_STEP;
    else
      st_next.mic_gain = st_reg.mic_base;
    // Audio muted in idle and while a preset is loading
    st_next.audio.valid = audio_i.valid && st_reg.fsm == ST_RUN && st_reg.mode != MODE_IDLE;
    st_next.audio.sample = st_next.audio.valid ? scaled : 16'h0000;
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      st_reg <= HAP_STATE_RST;
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state register
  assign rdata_o = st_reg.rdata;
  assign spk_ctrl_o = st_reg.spk_out;
  assign vref_en_o = st_reg.vref_en;
  assign sidetone_en_o = st_reg.sidetone_en;
  assign sidetone_level_o = st_reg.sidetone_lvl;
  assign aec_en_o = st_reg.aec_en;
  assign alert_tone_en_o = st_reg.alert_en;
  assign mic_gain_o = st_reg.mic_gain;
  assign eq_coef_o = st_reg.eq;
  assign audio_o = st_reg.audio;

  // Checks on mode sequencing, amplifier control and audio
  sequence s_mode_wr;
    bus_i.wr && bus_i.addr == REG_MODE && bus_i.wdata[2:0] <= 3'(MODE_ALERT);
  endsequence

  sequence s_loading;
    st_reg.fsm == ST_LOAD;
  endsequence

  property p_mode_load;
    @(posedge sys_clk_i) disable iff (reset_i)
    s_mode_wr ##1 (s_loading and !bus_i.wr) |=> st_reg.active == $past(st_reg.presets[st_reg.mode]);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("preset not loaded on mode change");

  property p_idle_shut;
    @(posedge sys_clk_i) disable iff (reset_i)
    (st_reg.mode == MODE_IDLE && !st_reg.shut_dis) |=>
      ((spk_ctrl_o & OFF_MASK) == OFF_MASK) && !vref_en_o;
  endproperty
  a_idle_shut: assert property (p_idle_shut) else $error("idle shutdown missing");

  property p_gnd_on;
    @(posedge sys_clk_i) disable iff (reset_i)
    (!spk_ctrl_o[P_OFF_BIT] || !spk_ctrl_o[N_OFF_BIT] || !spk_ctrl_o[HS_OFF_BIT])
      |-> !spk_ctrl_o[GND_OFF_BIT];
  endproperty
  a_gnd_on: assert property (p_gnd_on) else $error("ground amp off while amps run");

  property p_speaker;
    @(posedge sys_clk_i) disable iff (reset_i)
    st_reg.mode == MODE_SPEAKER |=> aec_en_o && !sidetone_en_o;
  endproperty
  a_speaker: assert property (p_speaker) else $error("speakerphone controls wrong");

  property p_earpiece;
    @(posedge sys_clk_i) disable iff (reset_i)
    st_reg.mode == MODE_EARPIECE && $stable(st_reg.mode) |-> sidetone_en_o && !aec_en_o;
  endproperty
  a_earpiece: assert property (p_earpiece) else $error("earpiece sidetone missing");

  property p_alert;
    @(posedge sys_clk_i) disable iff (reset_i)
    st_reg.mode == MODE_ALERT [*2] |-> alert_tone_en_o;
  endproperty
  a_alert: assert property (p_alert) else $error("alert tone not enabled");

  property p_damp_limit;
    @(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |=> mic_gain_o <= $past(st_reg.mic_base) &&
      4'($past(st_reg.mic_base) - mic_gain_o) <= MIC_DAMP_STEP;
  endproperty
  a_damp_limit: assert property (p_damp_limit) else $error("mic damping over 2 dB");

  property p_vol_idle;
    @(posedge sys_clk_i) disable iff (reset_i)
    bus_i.wr && bus_i.addr == REG_VOL && st_reg.mode == MODE_IDLE |=> $stable(st_reg.vol_step);
  endproperty
  a_vol_idle: assert property (p_vol_idle) else $error("volume changed in idle");

  property p_unity;
    @(posedge sys_clk_i) disable iff (reset_i)
    audio_i.valid && audio_i.tone == 16'h0000 && step_gain == VOL_GAIN_RST &&
      st_reg.fsm == ST_RUN && st_reg.mode != MODE_IDLE |=> audio_o.valid &&
      audio_o.sample == $past(audio_i.sample);
  endproperty
  a_unity: assert property (p_unity) else $error("unity step not unity");

  property p_eq_reload;
    @(posedge sys_clk_i) disable iff (reset_i)
    bus_i.wr && bus_i.addr == REG_EQ_CMD && bus_i.wdata[0] |=> eq_coef_o[0] == EQ_BYPASS;
  endproperty
  a_eq_reload: assert property (p_eq_reload) else $error("equaliser not bypassed");

  property p_vol_refuse;
    @(posedge sys_clk_i) disable iff (reset_i)
    bus_i.wr && bus_i.addr == REG_VOL && bus_i.wdata[3:0] > VOL_STEP_MAX |=>
      $stable(st_reg.vol_step);
  endproperty
  a_vol_refuse: assert property (p_vol_refuse) else $error("volume step past last taken");

  property p_vol_range;
    @(posedge sys_clk_i) disable iff (reset_i)
    st_reg.vol_step <= VOL_STEP_MAX;
  endproperty
  a_vol_range: assert property (p_vol_range) else $error("volume step out of range");

  property p_vref_on;
    @(posedge sys_clk_i) disable iff (reset_i)
    !idle_shut |=> vref_en_o;
  endproperty
  a_vref_on: assert property (p_vref_on) else $error("references off outside shutdown");

  property p_damp_on;
    @(posedge sys_clk_i) disable iff (reset_i)
    step_gain[15] && st_reg.mic_base >= MIC_DAMP_STEP |=>
      mic_gain_o == $past(st_reg.mic_base) - MIC_DAMP_STEP;
  endproperty
  a_damp_on: assert property (p_damp_on) else $error("mic damping not applied");

  property p_no_damp;
    @(posedge sys_clk_i) disable iff (reset_i)
    !step_gain[15] |=> mic_gain_o == $past(st_reg.mic_base);
  endproperty
  a_no_damp: assert property (p_no_damp) else $error("mic gain differs from base");

  property p_load_one;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_loading and !bus_i.wr) |=> st_reg.fsm == ST_RUN;
  endproperty
  a_load_one: assert property (p_load_one) else $error("preset load not one cycle");

  property p_eq_write;
    @(posedge sys_clk_i) disable iff (reset_i)
    bus_i.wr && bus_i.addr == REG_EQ_BASE + 8'h01 |=> eq_coef_o[1] == $past(bus_i.wdata);
  endproperty
  a_eq_write: assert property (p_eq_write) else $error("equaliser load lost");

  property p_gain_pass;
    @(posedge sys_clk_i) disable iff (reset_i)
    !idle_shut |=> (spk_ctrl_o & 16'hFBFF) == ($past(st_reg.active) & 16'hFBFF);
  endproperty
  a_gain_pass: assert property (p_gain_pass) else $error("speaker fields altered");
endmodule
`default_nettype wire

// >>> test/hap_amp_model.sv
// Far-side amplifier front end model watching the speaker control word
`timescale 1ns/10ps
`default_nettype none
module hap_amp_model
  import hap_pkg::*;
(
  input wire logic [15:0] spk_ctrl_i,
  input wire logic vref_en_i,
  output logic gnd_fault_o,
  output logic [2:0] amps_on_o
);
  // Running amps: clear power-down bit with references up
  assign amps_on_o = vref_en_i ? 3'(!spk_ctrl_i[HS_OFF_BIT]) + 3'(!spk_ctrl_i[N_OFF_BIT])
    + 3'(!spk_ctrl_i[P_OFF_BIT]) : 3'h0;
  // Ground amp off while another amp runs is a fault
  assign gnd_fault_o = (amps_on_o != 3'h0) && spk_ctrl_i[GND_OFF_BIT];
endmodule
`default_nettype wire

// >>> test/hap_top_tb_top.sv
// Self-checking bench for the handset audio path configuration bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module hap_top_tb_top
  import hap_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] e;} hap_row_t;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  hap_bus_req_t bus_i = '0;
  hap_audio_in_t audio_i = '0;
  logic [15:0] rdata_o;
  logic [15:0] spk_ctrl_o;
  logic [15:0] q;
  logic vref_en_o, sidetone_en_o, aec_en_o, alert_tone_en_o, gnd_fault;
  logic [7:0] sidetone_level_o;
  logic [3:0] mic_gain_o;
  logic [2:0] amps_on;
  logic [NUM_EQ-1:0][15:0] eq_coef_o;
  hap_audio_out_t audio_o;
  logic [15:0] presets [5] = '{16'h1D36, 16'h1912, 16'h0B33, 16'h1AF6, 16'h0333};
  logic [3:0] flags [5] = '{4'h0, 4'hC, 4'hA, 4'hC, 4'h9};
  logic [2:0] amps [5] = '{3'h0, 3'h2, 3'h1, 3'h1, 3'h1};
  hap_row_t rows [19] = '{
    {1'b0, 8'h0B, 16'h0000, 16'h0071}, {1'b1, 8'h0B, 16'hFFFF, 16'h0071},
    {1'b0, 8'h00, 16'h0000, 16'h1D36}, {1'b0, 8'h01, 16'h0000, 16'h1D36},
    {1'b0, 8'h02, 16'h0000, 16'h1912}, {1'b0, 8'h03, 16'h0000, 16'h0B33},
    {1'b0, 8'h04, 16'h0000, 16'h1AF6}, {1'b0, 8'h05, 16'h0000, 16'h0333},
    {1'b0, 8'h07, 16'h0000, 16'h1000}, {1'b0, 8'h08, 16'h0000, 16'h0005},
    {1'b0, 8'h10, 16'h0000, 16'h4000}, {1'b0, 8'h19, 16'h0000, 16'h4000},
    {1'b0, 8'h23, 16'h0000, 16'h7FFF}, {1'b1, 8'h19, 16'h7FFF, 16'h7FFF},
    {1'b1, 8'h09, 16'h000F, 16'h000F}, {1'b0, 8'h0A, 16'h0000, 16'h0000},
    {1'b0, 8'h3F, 16'h0000, 16'h0000}, {1'b1, 8'h3F, 16'h1234, 16'h0000},
    {1'b1, 8'h08, 16'h0003, 16'h0005}};
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  hap_top u_hap_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_i(bus_i),
    .audio_i(audio_i), .rdata_o(rdata_o), .spk_ctrl_o(spk_ctrl_o), .vref_en_o(vref_en_o),
    .sidetone_en_o(sidetone_en_o), .sidetone_level_o(sidetone_level_o), .aec_en_o(aec_en_o),
    .alert_tone_en_o(alert_tone_en_o), .mic_gain_o(mic_gain_o), .eq_coef_o(eq_coef_o),
    .audio_o(audio_o));
  hap_amp_model u_hap_amp_model (.spk_ctrl_i(spk_ctrl_o), .vref_en_i(vref_en_o),
    .gnd_fault_o(gnd_fault), .amps_on_o(amps_on));

  // Clock, 50 ns period
  initial
  begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      $display("Run stopped by cycle limit");
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus_i.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk_i);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus_i.rd <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic set_mode(input logic [2:0] m);
    wr_reg(REG_MODE, {13'h0000, m});
    settle();
  endtask

  task automatic audio_chk(input logic [15:0] s, input logic [15:0] t,
    input logic [15:0] e, input logic v);
    @(posedge sys_clk_i);
    audio_i <= '{valid: 1'b1, sample: s, tone: t};
    @(posedge sys_clk_i);
    audio_i.valid <= 1'b0;
    #1;
    `CHK({audio_o.valid, audio_o.sample}, {v, e})
  endtask

  // Word seen by the amplifiers for a stored word
  function automatic logic [15:0] eff(input logic [15:0] w, input logic shut);
    if (shut)
      return (w & ~16'h02DB) | 16'h0524;
    return (w[2] && w[5] && w[8]) ? w : (w & ~16'h0400);
  endfunction

  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
    `CHK(spk_ctrl_o, 16'h1D24)
    `CHK({vref_en_o, mic_gain_o, eq_coef_o}, {1'b0, 4'h7, {4{16'h7FFF}}})
    $display("Test reset done");
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, q);
      `CHK(q, rows[i].e)
    end
    $display("Test register table done");
    for (int m = 0; m < 5; m++)
    begin
      set_mode(3'(m));
      `CHK(spk_ctrl_o, eff(presets[m], m == 0))
      `CHK({vref_en_o, sidetone_en_o, aec_en_o, alert_tone_en_o}, flags[m])
      `CHK({gnd_fault, amps_on}, {1'b0, amps[m]})
    end
    $display("Test modes done");
    wr_reg(REG_CFG, 16'h2001);
    set_mode(3'h0);
    `CHK({spk_ctrl_o, vref_en_o, sidetone_level_o}, {16'h1D36, 1'b1, 8'h20})
    wr_reg(REG_CFG, 16'h1000);
    set_mode(3'h5);
    rd_reg(REG_MODE, q);
    `CHK({q, spk_ctrl_o}, {16'h0000, 16'h1D24})
    audio_chk(16'h1000, 16'h0000, 16'h0000, 1'b0);
    $display("Test idle done");
    set_mode(3'h1);
    wr_reg(REG_ACTIVE, 16'h3C00);
    settle();
    `CHK(spk_ctrl_o, 16'h3800)
    wr_reg(REG_ACTIVE, 16'h3D24);
    settle();
    `CHK(spk_ctrl_o, 16'h3D24)
    $display("Test active word done");
    wr_reg(REG_MIC, 16'h0007);
    wr_reg(REG_VGAIN_BASE + 8'h03, 16'hC000);
    wr_reg(REG_VOL, 16'h0003);
    settle();
    `CHK(mic_gain_o, 4'h6)
    wr_reg(REG_VGAIN_BASE + 8'h04, 16'h8000);
    wr_reg(REG_VOL, 16'h0004);
    settle();
    rd_reg(REG_STATUS, q);
    `CHK({q, mic_gain_o}, {16'h006C, 4'h6})
    wr_reg(REG_MIC, 16'h0000);
    wr_reg(REG_VOL, 16'h000A);
    settle();
    rd_reg(REG_VOL, q);
    `CHK({q, mic_gain_o}, {16'h0004, 4'h0})
    $display("Test mic damping done");
    wr_reg(REG_VOL, 16'h0005);
    settle();
    audio_chk(16'h1000, 16'h0000, 16'h1000, 1'b1);
    audio_chk(16'h1000, 16'h0800, 16'h1800, 1'b1);
    audio_chk(16'h7000, 16'h7000, 16'h7FFF, 1'b1);
    audio_chk(16'h9000, 16'h9000, 16'h8000, 1'b1);
    audio_chk(16'hF000, 16'h0000, 16'hF000, 1'b1);
    wr_reg(REG_VOL, 16'h0009);
    settle();
    audio_chk(16'h1000, 16'h0000, 16'h1FFF, 1'b1);
    $display("Test volume stage done");
    wr_reg(REG_EQ_BASE + 8'h00, 16'h5678);
    wr_reg(REG_EQ_BASE + 8'h01, 16'h1234);
    settle();
    `CHK({eq_coef_o[1], eq_coef_o[0]}, {16'h1234, 16'h5678})
    wr_reg(REG_EQ_CMD, 16'h0003);
    settle();
    `CHK(eq_coef_o, {4{16'h7FFF}})
    $display("Test equaliser done");
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    `CHK({spk_ctrl_o, mic_gain_o, audio_o}, {16'h1D24, 4'h7, 17'h00000})
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd_reg(REG_MODE, q);
    `CHK({q, spk_ctrl_o, vref_en_o}, {16'h0000, 16'h1D24, 1'b0})
    $display("Test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
